// file: dspc_defs.svh
// Constants of the numeric datapath: widths, reset values, limits and frame counts
`ifndef DSPC_DEFS_SVH
`define DSPC_DEFS_SVH

// ***********************************************
// Word widths
// ***********************************************
`define DSPC_IO_BITS          24
`define DSPC_CORE_BITS        28
`define DSPC_FRAC_BITS        23
`define DSPC_ACC_BITS         56
`define DSPC_PARAM_BITS       32
`define DSPC_PAD_BITS         4

// ***********************************************
// Frame timing
// ***********************************************
`define DSPC_INSTR_PER_SAMPLE 1024
`define DSPC_PC_BITS          10
`define DSPC_LAST_NORMAL      10'h3FF
`define DSPC_LAST_DOUBLE      10'h1FF
`define DSPC_LAST_QUAD        10'h0FF
`define DSPC_SPEED_NORMAL     2'h0
`define DSPC_SPEED_DOUBLE     2'h1

// ***********************************************
// Reset values and limits
// ***********************************************
`define DSPC_COEF_RESET       32'h0080_0000
`define DSPC_OUT_MAX          24'h7F_FFFF
`define DSPC_OUT_MIN          24'h80_0000
`define DSPC_CORE_MAX         28'h7FF_FFFF
`define DSPC_CORE_MIN         28'h800_0000
`define DSPC_FIFO_DEPTH       32
`define DSPC_SYNC_STAGES      3
`define DSPC_SYNC_BITS        3

`endif

// file: dspc_pkg.sv
// Types shared by the numeric datapath files
`default_nettype none
`include "dspc_defs.svh"

package dspc_pkg;

  // Sequencer steps inside one sample frame
  typedef enum logic [4:0] {
    DSPC_LOAD = 5'h01,
    DSPC_MAC  = 5'h02,
    DSPC_NORM = 5'h04,
    DSPC_RUN  = 5'h08,
    DSPC_EMIT = 5'h10
  } dspc_state_e;

  typedef logic signed [`DSPC_CORE_BITS-1:0] dspc_word_t;
  typedef logic signed [`DSPC_ACC_BITS-1:0]  dspc_acc_t;

endpackage : dspc_pkg
`default_nettype wire

// file: dspc_fifo.sv
// Output sample FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module dspc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire              full;
  wire              empty;
  wire              doWrite;
  wire              doRead;

  // ***********************************************
  // Status decode
  // ***********************************************
  // Extra pointer bit tells full from empty
  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty    = (wrPtr == rdPtr);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign doWrite  = inValid & ~full;
  assign doRead   = outReady & ~empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  // Storage write
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule : dspc_fifo
`default_nettype wire

// file: dspc_core.sv
// Numeric datapath and frame sequencer of the audio processing core
`timescale 1ns/100ps
`default_nettype none
`include "dspc_defs.svh"

module dspc_core #(
  parameter int FIFO_DEPTH = `DSPC_FIFO_DEPTH
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [`DSPC_IO_BITS-1:0]    sampleIn,
  input  wire logic                        sampleInValid,
  output logic                             sampleInReady,
  input  wire logic [`DSPC_PARAM_BITS-1:0] coefWord,
  input  wire logic                        coefLoad,
  input  wire logic                        unmutePin,
  input  wire logic [1:0]                  speedPin,
  output logic [`DSPC_IO_BITS-1:0]         sampleOut,
  output logic                             sampleOutValid,
  input  wire logic                        sampleOutReady,
  output logic                             frameStart,
  output logic                             muted
);

  // ***********************************************
  // Declarations
  // ***********************************************
  dspc_pkg::dspc_state_e          state;
  dspc_pkg::dspc_state_e          next_state;
  logic [`DSPC_PC_BITS-1:0]       pc;
  logic [`DSPC_PC_BITS-1:0]       frameLast;
  logic [`DSPC_SYNC_BITS-1:0]     syncA;
  logic [`DSPC_SYNC_BITS-1:0]     syncB;
  logic [`DSPC_SYNC_BITS-1:0]     syncC;
  logic [`DSPC_SYNC_BITS-1:0]     pinStable;
  logic [`DSPC_PARAM_BITS-1:0]    coefStore;
  dspc_pkg::dspc_word_t           acc28;
  dspc_pkg::dspc_acc_t            prod;
  dspc_pkg::dspc_word_t           norm28;
  wire  [`DSPC_SYNC_BITS-1:0]     pinRaw;
  wire  [1:0]                     speedSel;
  wire  [`DSPC_PC_BITS-1:0]       lastSel;
  dspc_pkg::dspc_word_t           inExt;
  dspc_pkg::dspc_word_t           coef28;
  dspc_pkg::dspc_acc_t            mulOut;
  wire                            prodOvf;
  dspc_pkg::dspc_word_t           prodSat;
  wire                            clipOvf;
  wire  [`DSPC_IO_BITS-1:0]       clipped;
  wire  [`DSPC_IO_BITS-1:0]       pushWord;
  wire                            pushValid;
  wire                            pushReady;
  wire                            emitDone;

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  assign pinRaw = {speedPin, unmutePin};

  // Three stages per pin; a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < `DSPC_SYNC_BITS; i++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          syncA[i]     <= 1'b0;
          syncB[i]     <= 1'b0;
          syncC[i]     <= 1'b0;
          pinStable[i] <= 1'b0;
        end else begin
          syncA[i] <= pinRaw[i];
          syncB[i] <= syncA[i];
          syncC[i] <= syncB[i];
          if (syncB[i] == syncC[i]) begin
            pinStable[i] <= syncC[i];
          end
        end
      end
    end
  endgenerate

  assign speedSel = pinStable[2:1];

  // ***********************************************
  // Frame length selection
  // ***********************************************
  // speed setting shortens the frame
  assign lastSel = (speedSel == `DSPC_SPEED_NORMAL) ? `DSPC_LAST_NORMAL :
                   (speedSel == `DSPC_SPEED_DOUBLE) ? `DSPC_LAST_DOUBLE :
                   `DSPC_LAST_QUAD;

  // ***********************************************
  // Sequencer
  // ***********************************************
  assign emitDone = (state == dspc_pkg::DSPC_EMIT) && pushReady;

  // fixed step order, no branches on data
  always_comb begin
    next_state = state;
    unique case (state)
      dspc_pkg::DSPC_LOAD: next_state = dspc_pkg::DSPC_MAC;
      dspc_pkg::DSPC_MAC:  next_state = dspc_pkg::DSPC_NORM;
      dspc_pkg::DSPC_NORM: next_state = dspc_pkg::DSPC_RUN;
      dspc_pkg::DSPC_RUN: begin
        if (pc == frameLast - 1'b1) begin
          next_state = dspc_pkg::DSPC_EMIT;
        end
      end
      dspc_pkg::DSPC_EMIT: begin
        if (pushReady) begin
          next_state = dspc_pkg::DSPC_LOAD;
        end
      end
      default: next_state = dspc_pkg::DSPC_LOAD;
    endcase
  end

  // instruction counter wraps after the last cycle of the frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= dspc_pkg::DSPC_LOAD;
      pc        <= '0;
      frameLast <= `DSPC_LAST_NORMAL;
    end else begin
      state <= next_state;
      if (emitDone) begin
        pc <= '0;
      end else if (state != dspc_pkg::DSPC_EMIT) begin
        pc <= pc + 1'b1;
      end
      if (state == dspc_pkg::DSPC_LOAD) begin
        frameLast <= lastSel;
      end
    end
  end

  assign sampleInReady = (state == dspc_pkg::DSPC_LOAD);
  assign frameStart    = (state == dspc_pkg::DSPC_LOAD);

  // ***********************************************
  // Coefficient store
  // ***********************************************
  // reset value is unity gain, giving pass-through
  // upper four bits forced to zero on load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coefStore <= `DSPC_COEF_RESET;
    end else if (coefLoad) begin
      coefStore <= {{`DSPC_PAD_BITS{1'b0}}, coefWord[`DSPC_CORE_BITS-1:0]};
    end
  end

  // ***********************************************
  // Arithmetic
  // ***********************************************
  // sign extension to the core width; absent sample reads as zero
  assign inExt  = sampleInValid ?
                  dspc_pkg::dspc_word_t'({{`DSPC_PAD_BITS{sampleIn[`DSPC_IO_BITS-1]}}, sampleIn}) : '0;
  assign coef28 = dspc_pkg::dspc_word_t'(coefStore[`DSPC_CORE_BITS-1:0]);
  assign mulOut = acc28 * coef28;

  // product back to 5.23, saturating outside the core range
  assign prodOvf = (prod[`DSPC_ACC_BITS-1:`DSPC_CORE_BITS+`DSPC_FRAC_BITS-1] != '0) &&
                   (prod[`DSPC_ACC_BITS-1:`DSPC_CORE_BITS+`DSPC_FRAC_BITS-1] != '1);
  assign prodSat = prodOvf ? (prod[`DSPC_ACC_BITS-1] ? `DSPC_CORE_MIN : `DSPC_CORE_MAX) :
                   prod[`DSPC_CORE_BITS+`DSPC_FRAC_BITS-1:`DSPC_FRAC_BITS];

  // Datapath registers, one step in each of the LOAD, MAC and NORM states
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc28  <= '0;
      prod   <= '0;
      norm28 <= '0;
    end else begin
      if (state == dspc_pkg::DSPC_LOAD) begin
        acc28 <= inExt;
      end
      if (state == dspc_pkg::DSPC_MAC) begin
        prod <= mulOut;
      end
      if (state == dspc_pkg::DSPC_NORM) begin
        norm28 <= prodSat;
      end
    end
  end

  // ***********************************************
  // Output clipper and mute
  // ***********************************************
  // headroom bits must all match the sign to pass unclipped
  assign clipOvf = (norm28[`DSPC_CORE_BITS-1:`DSPC_IO_BITS-1] != '0) &&
                   (norm28[`DSPC_CORE_BITS-1:`DSPC_IO_BITS-1] != '1);
  assign clipped = clipOvf ? (norm28[`DSPC_CORE_BITS-1] ? `DSPC_OUT_MIN : `DSPC_OUT_MAX) :
                   norm28[`DSPC_IO_BITS-1:0];
  assign pushWord  = muted ? '0 : clipped;
  assign pushValid = (state == dspc_pkg::DSPC_EMIT);

  // mute held from reset until the unmute pin settles high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      muted <= 1'b1;
    end else begin
      muted <= ~pinStable[0];
    end
  end

  // ***********************************************
  // Output buffer
  // ***********************************************
  // 24-bit words leave the core
  dspc_fifo #(
    .WIDTH (`DSPC_IO_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .rst      (rst),
    .inData   (pushWord),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .outData  (sampleOut),
    .outValid (sampleOutValid),
    .outReady (sampleOutReady)
  );

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic coefTouched;

  // Helper: marks the first parameter load after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coefTouched <= 1'b0;
    end else if (coefLoad) begin
      coefTouched <= 1'b1;
    end
  end

  a_frame_wrap: assert property (
    emitDone |=> (state == dspc_pkg::DSPC_LOAD) && (pc == '0))
    else $error("Frame did not restart after emit");

  a_run_count: assert property (
    (state == dspc_pkg::DSPC_RUN) && (pc == frameLast - 1'b1) |=> (state == dspc_pkg::DSPC_EMIT) && (pc == frameLast))
    else $error("Emit not on last instruction");

  a_speed_len: assert property (
    (state == dspc_pkg::DSPC_LOAD) && (speedSel == `DSPC_SPEED_DOUBLE) |=> frameLast == `DSPC_LAST_DOUBLE)
    else $error("Double speed frame length wrong");

  a_sign_ext: assert property (
    (state == dspc_pkg::DSPC_LOAD) && sampleInValid |=>
      acc28 == dspc_pkg::dspc_word_t'($signed($past(sampleIn))))
    else $error("Input sample not sign extended");

  a_mac_full: assert property (
    state == dspc_pkg::DSPC_MAC |=> prod == $past(acc28) * $past(coef28))
    else $error("Product not full precision");

  a_clip_pos: assert property (
    (state == dspc_pkg::DSPC_EMIT) && !muted && !norm28[`DSPC_CORE_BITS-1] && clipOvf |-> pushWord == `DSPC_OUT_MAX)
    else $error("Positive overflow not saturated");

  a_clip_pass: assert property (
    (state == dspc_pkg::DSPC_EMIT) && !muted && !clipOvf |-> pushWord == norm28[`DSPC_IO_BITS-1:0])
    else $error("In-range value altered by clipper");

  a_mute_zero: assert property (
    (state == dspc_pkg::DSPC_EMIT) && muted |-> pushWord == '0)
    else $error("Muted output not silent");

  a_param_pad: assert property (
    coefLoad |=> coefStore[`DSPC_PARAM_BITS-1:`DSPC_CORE_BITS] == '0)
    else $error("Parameter padding not zero");

  a_default_unity: assert property (
    !coefTouched |-> coefStore == `DSPC_COEF_RESET)
    else $error("Default gain not unity");

  c_sample_out: cover property (emitDone && !muted);
  c_unmute: cover property ($fell(muted));
  c_quad: cover property ((state == dspc_pkg::DSPC_LOAD) ##1 frameLast == `DSPC_LAST_QUAD);
  c_clip: cover property ((state == dspc_pkg::DSPC_EMIT) && clipOvf);

endmodule : dspc_core
`default_nettype wire

// file: dspc_sink.sv
// Output-side partner: a converter that takes words promptly, slowly or not at all
`timescale 1ns/100ps
`default_nettype none

module dspc_sink (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [1:0] mode,
  input  wire logic       sampleOutValid,
  output var logic        sampleOutReady
);
  logic phase;

  // Mode 0 accepts every cycle, mode 1 every other offered cycle, mode 2 holds off
  initial begin
    sampleOutReady = 1'b0;
    phase = 1'b0;
    forever begin
      @(posedge mclk);
      // Rhythm advances only while a word is on offer
      if (sampleOutValid) begin
        phase = ~phase;
      end
      sampleOutReady <= #1 !rst && (mode == 2'h0 || (mode == 2'h1 && phase));
    end
  end
endmodule : dspc_sink
`default_nettype wire

// file: tb.sv
// Self-checking testbench of the numeric datapath core
`timescale 1ns/100ps
`default_nettype none
`include "dspc_defs.svh"

module tb;
  typedef struct {
    logic [23:0] val;
    logic        chk;
  } dspc_note_s;

  logic        mclk;
  logic        rst;
  logic [23:0] sampleIn;
  logic        sampleInValid;
  logic        sampleInReady;
  logic [31:0] coefWord;
  logic        coefLoad;
  logic        unmutePin;
  logic [1:0]  speedPin;
  logic [23:0] sampleOut;
  logic        sampleOutValid;
  logic        sampleOutReady;
  logic        frameStart;
  logic        muted;
  logic [1:0]  sinkMode;
  logic [31:0] seed;
  logic [31:0] coefExp;
  logic        muteExp;
  dspc_note_s  noteQ[$];
  dspc_note_s  note;
  // Gains: unity, unity with junk pad bits, minus sixteen, near sixteen, two, one half
  logic [31:0] gainTab [6] = '{32'h0080_0000, 32'hF080_0000, 32'h0800_0000, 32'h07FF_FFFF, 32'h0100_0000,
                               32'h0040_0000};
  int          skip;
  int          taken;
  int          held;
  int          cycles;
  int          failCount;
  int          nTests;

  dspc_core #(.FIFO_DEPTH(`DSPC_FIFO_DEPTH)) dspc_core_i (.mclk(mclk), .rst(rst), .sampleIn(sampleIn),
    .sampleInValid(sampleInValid), .sampleInReady(sampleInReady), .coefWord(coefWord), .coefLoad(coefLoad),
    .unmutePin(unmutePin), .speedPin(speedPin), .sampleOut(sampleOut), .sampleOutValid(sampleOutValid),
    .sampleOutReady(sampleOutReady), .frameStart(frameStart), .muted(muted));
  dspc_sink dspc_sink_i (.mclk(mclk), .rst(rst), .mode(sinkMode), .sampleOutValid(sampleOutValid),
    .sampleOutReady(sampleOutReady));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xorshift

  // Expected output word for one taken sample
  function automatic logic [23:0] expv(input logic [23:0] s, input logic [31:0] c, input logic m);
    dspc_pkg::dspc_acc_t  p;
    dspc_pkg::dspc_word_t w;
    p = $signed({{4{s[23]}}, s}) * $signed(c[27:0]);
    p = p >>> 23;
    w = (p[55:27] != {29{p[55]}}) ? (p[55] ? `DSPC_CORE_MIN : `DSPC_CORE_MAX) : p[27:0];
    if (m) return 24'h00_0000;
    if (w[27:23] != {5{w[27]}}) return w[27] ? `DSPC_OUT_MIN : `DSPC_OUT_MAX;
    return w[23:0];
  endfunction : expv

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    failCount++;
    $display("mismatch at %0t: got %h expected %h", $time, got, exp);
  endtask : report

  task automatic cmpWord(input logic [23:0] got, input logic [23:0] exp);
    nTests++;
    if (got !== exp) report({8'h00, got}, {8'h00, exp});
  endtask : cmpWord

  task automatic cmpFlag(input logic got, input logic exp);
    nTests++;
    if (got !== exp) report({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : cmpFlag

  task automatic cmpCount(input int got, input int exp);
    nTests++;
    if (got != exp) report(got, exp);
  endtask : cmpCount

  task automatic printVerdict;
    if (failCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : printVerdict

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // Frames in flight while a setting moves are not judged
  function automatic void hold;
    foreach (noteQ[i]) noteQ[i].chk = 1'b0;
    skip = 1;
  endfunction : hold

  task automatic setCoef(input logic [31:0] c);
    coefWord = c;
    coefLoad = 1'b1;
    tick(1);
    coefLoad = 1'b0;
    coefExp = c;
    hold();
  endtask : setCoef

  task automatic setMute(input logic m);
    unmutePin = !m;
    muteExp = m;
    hold();
  endtask : setMute

  // Cycles from one frame start to the next
  task automatic period(input int exp);
    int n;
    n = 0;
    while (frameStart !== 1'b1) tick(1);
    tick(1);
    while (frameStart !== 1'b1) begin
      tick(1);
      n++;
    end
    cmpCount(n + 1, exp);
  endtask : period

  // ***********************************************
  // Clock and hang guard
  // ***********************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      failCount++;
      printVerdict();
    end
  end

  // Driver: notes each taken sample, then offers a fresh one
  always @(posedge mclk) begin
    if (!rst && sampleInReady === 1'b1) begin
      noteQ.push_back('{expv(sampleInValid ? sampleIn : 24'h00_0000, coefExp, muteExp), skip == 0});
      taken++;
      if (skip > 0) skip--;
    end
    seed = xorshift(seed);
    sampleIn <= #1 (seed[1:0] == 2'h0) ? `DSPC_OUT_MAX : (seed[1:0] == 2'h1) ? `DSPC_OUT_MIN : seed[31:8];
    sampleInValid <= #1 (seed[6:4] != 3'h0);
  end

  // Monitor: each accepted word against the oldest note
  always @(posedge mclk) begin
    if (!rst && sampleOutValid === 1'b1 && sampleOutReady === 1'b1) begin
      cmpFlag(noteQ.size() > 0, 1'b1);
      if (noteQ.size() > 0) begin
        note = noteQ.pop_front();
        if (note.chk) cmpWord(sampleOut, note.val);
      end
    end
  end

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    rst = 1'b1;
    sampleIn = 24'h00_0000;
    sampleInValid = 1'b0;
    coefWord = 32'h0000_0000;
    coefLoad = 1'b0;
    unmutePin = 1'b0;
    speedPin = 2'h0;
    sinkMode = 2'h0;
    seed = 32'h0001_0D9A;
    coefExp = `DSPC_COEF_RESET;
    muteExp = 1'b1;
    {skip, taken, cycles, failCount, nTests} = '0;
    tick(3);
    cmpFlag(muted, 1'b1);
    rst = 1'b0;
    period(1024);
    period(1024);
    setMute(1'b0);
    for (int s = 1; s < 4; s++) begin
      speedPin = s[1:0];
      tick(10);
      period(s == 1 ? 512 : 256);
    end
    foreach (gainTab[i]) begin
      setCoef(gainTab[i]);
      tick(1280);
    end
    repeat (4) begin
      setCoef({4'h0, seed[27:0]});
      tick(1280);
    end
    sinkMode = 2'h1;
    tick(2560);
    // back-pressure fills the buffer, then frames stop
    sinkMode = 2'h2;
    taken = 0;
    tick(256 * 40);
    cmpFlag(taken >= `DSPC_FIFO_DEPTH && taken <= `DSPC_FIFO_DEPTH + 2, 1'b1);
    held = taken;
    tick(1024);
    cmpCount(taken, held);
    sinkMode = 2'h0;
    tick(1024);
    setMute(1'b1);
    tick(1024);
    rst = 1'b1;
    noteQ.delete();
    tick(2);
    cmpFlag(muted, 1'b1);
    cmpFlag(sampleOutValid, 1'b0);
    coefExp = `DSPC_COEF_RESET;
    rst = 1'b0;
    setMute(1'b0);
    tick(8);
    cmpFlag(muted, 1'b0);
    tick(2048);
    printVerdict();
  end
endmodule : tb
`default_nettype wire
